// ==== rtl/crf_params.svh ====
// constants for the cpu register and addressing block
`ifndef CRF_PARAMS_SVH
`define CRF_PARAMS_SVH
`define CRF_SP_RESET      6'h3f
`define CRF_SP_UPPER      7'h03
`define CRF_FLAG_UPPER    3'h7
`define CRF_PC_RESET      13'h0000
`define CRF_MUL_CYCLES    4'hb
`define CRF_FLAG_H        4
`define CRF_FLAG_I        3
`define CRF_FLAG_N        2
`define CRF_FLAG_Z        1
`define CRF_FLAG_C        0
`define CRF_INT_BYTES     3'h5
`define CRF_CALL_BYTES    3'h2
`endif

// ==== rtl/crf_pkg.sv ====
// types for the cpu register and addressing block
package crf_pkg;
  typedef enum logic [2:0] {
    CRF_MODE_INHERENT,
    CRF_MODE_IMMEDIATE,
    CRF_MODE_DIRECT,
    CRF_MODE_IDX0,
    CRF_MODE_IDX8,
    CRF_MODE_IDX16
  } crf_mode_t;
  typedef enum logic [3:0] {
    CRF_ALU_NONE,
    CRF_ALU_ADD,
    CRF_ALU_ADC,
    CRF_ALU_SUB,
    CRF_ALU_SBC,
    CRF_ALU_AND,
    CRF_ALU_OR,
    CRF_ALU_XOR,
    CRF_ALU_LOAD,
    CRF_ALU_SHL,
    CRF_ALU_SHR,
    CRF_ALU_ROL,
    CRF_ALU_ROR
  } crf_alu_t;
  typedef enum logic [1:0] {
    CRF_DST_A,
    CRF_DST_X,
    CRF_DST_NONE
  } crf_dst_t;
endpackage

// ==== rtl/crf_alu_if.sv ====
// alu request and result bundle between top and alu
`timescale 1ns/1ps
`default_nettype none
interface crf_alu_if;
  crf_pkg::crf_alu_t op;
  logic [7:0]        lhs;
  logic [7:0]        rhs;
  logic              carry_in;
  logic [7:0]        result;
  logic              half_carry;
  logic              carry_out;
  modport core (output op, lhs, rhs, carry_in, input result, half_carry, carry_out);
  modport alu  (input op, lhs, rhs, carry_in, output result, half_carry, carry_out);
endinterface
`default_nettype wire

// ==== rtl/crf_alu.sv ====
// combinational alu for add, subtract, logic and shifts
`timescale 1ns/1ps
`default_nettype none
module crf_alu (
  crf_alu_if.alu bus
);
  logic [8:0] sum;
  logic [4:0] low_sum;
  logic [7:0] addend;
  logic       cin;
  logic       is_sub;
  assign is_sub = (bus.op == crf_pkg::CRF_ALU_SUB) || (bus.op == crf_pkg::CRF_ALU_SBC);
  // subtract as addition of the negated operand
  assign addend = is_sub ? ~bus.rhs : bus.rhs;
  assign cin = (bus.op == crf_pkg::CRF_ALU_ADC) ? bus.carry_in :
               (bus.op == crf_pkg::CRF_ALU_SUB) ? 1'b1 :
               (bus.op == crf_pkg::CRF_ALU_SBC) ? ~bus.carry_in : 1'b0;
  assign sum = {1'b0, bus.lhs} + {1'b0, addend} + {8'h00, cin};
  assign low_sum = {1'b0, bus.lhs[3:0]} + {1'b0, addend[3:0]} + {4'h0, cin};
  always_comb begin
    bus.result = bus.lhs;
    bus.carry_out = bus.carry_in;
    bus.half_carry = low_sum[4];
    case (bus.op)
      crf_pkg::CRF_ALU_ADD, crf_pkg::CRF_ALU_ADC: begin
        bus.result = sum[7:0];
        bus.carry_out = sum[8];
      end
      crf_pkg::CRF_ALU_SUB, crf_pkg::CRF_ALU_SBC: begin
        bus.result = sum[7:0];
        bus.carry_out = ~sum[8];
      end
      crf_pkg::CRF_ALU_AND: bus.result = bus.lhs & bus.rhs;
      crf_pkg::CRF_ALU_OR: bus.result = bus.lhs | bus.rhs;
      crf_pkg::CRF_ALU_XOR: bus.result = bus.lhs ^ bus.rhs;
      crf_pkg::CRF_ALU_LOAD: bus.result = bus.rhs;
      crf_pkg::CRF_ALU_SHL: begin
        bus.result = {bus.lhs[6:0], 1'b0};
        bus.carry_out = bus.lhs[7];
      end
      crf_pkg::CRF_ALU_SHR: begin
        bus.result = {1'b0, bus.lhs[7:1]};
        bus.carry_out = bus.lhs[0];
      end
      crf_pkg::CRF_ALU_ROL: begin
        bus.result = {bus.lhs[6:0], bus.carry_in};
        bus.carry_out = bus.lhs[7];
      end
      crf_pkg::CRF_ALU_ROR: begin
        bus.result = {bus.carry_in, bus.lhs[7:1]};
        bus.carry_out = bus.lhs[0];
      end
      default: bus.result = bus.lhs;
    endcase
  end
endmodule // crf_alu
`default_nettype wire

// ==== rtl/crf_core.sv ====
// cpu programming model: registers, stack, flags, multiply, address forming
//////////////////////////////////////////////////////////////////////////////
//////////////////////////////////////////////////////////////////////////////
`timescale 1ns/1ps
`default_nettype none
`include "crf_params.svh"
module crf_core (
  input  wire logic                CORE_CLK_IN,
  input  wire logic                RST_B_IN,
  input  wire logic                FETCH_IN,
  input  wire logic                JUMP_IN,
  input  wire logic [12:0]         JUMP_TARGET_IN,
  input  wire logic                BRANCH_IN,
  input  wire logic                BRANCH_TAKEN_IN,
  input  wire logic [7:0]          BRANCH_OFFSET_IN,
  input  wire crf_pkg::crf_mode_t  MODE_IN,
  input  wire logic [7:0]          OPERAND1_IN,
  input  wire logic [7:0]          OPERAND2_IN,
  input  wire logic                ALU_GO_IN,
  input  wire crf_pkg::crf_alu_t   ALU_OP_IN,
  input  wire crf_pkg::crf_dst_t   ALU_DST_IN,
  input  wire logic [7:0]          ALU_DATA_IN,
  input  wire logic                BIT_TEST_IN,
  input  wire logic                BIT_VALUE_IN,
  input  wire logic                SET_MASK_IN,
  input  wire logic                CLEAR_MASK_IN,
  input  wire logic                SET_CARRY_IN,
  input  wire logic                CLEAR_CARRY_IN,
  input  wire logic                PUSH_IN,
  input  wire logic [7:0]          PUSH_DATA_IN,
  input  wire logic                PULL_IN,
  input  wire logic                STACK_REINIT_OP_IN,
  input  wire logic                CALL_IN,
  input  wire logic                PRODUCT_OP_IN,
  input  wire logic                IRQ_IN,
  input  wire logic                INTERRUPT_RETURN_OP_IN,
  input  wire logic [7:0]          PULL_DATA_IN,
  output logic [7:0]               ACCUMULATOR_OUT,
  output logic [7:0]               INDEX_OUT,
  output logic [15:0]              STACK_ADDR_OUT,
  output logic [15:0]              INSTRUCTION_POINTER_OUT,
  output logic [7:0]               FLAG_REGISTER_OUT,
  output logic [15:0]              OPERAND_ADDR_OUT,
  output logic                     ADDR_VALID_OUT,
  output logic [1:0]               INSTR_LENGTH_OUT,
  output logic                     INT_PENDING_OUT,
  output logic                     INT_TAKE_OUT,
  output logic [7:0]               STACK_WDATA_OUT,
  output logic                     STACK_WRITE_OUT,
  output logic                     BUSY_OUT
);
  typedef enum logic [2:0] {
    CRF_IDLE,
    CRF_INT_STACK,
    CRF_RET_PULL,
    CRF_CALL_STACK,
    CRF_MUL_RUN
  } crf_state_t;

  //////////////////////////////////////////////////////////////////////////////
  // registers
  // eight-bit working registers
  logic [7:0]  accumulator;
  logic [7:0]  index_reg;
  logic [5:0]  stack_pointer;
  logic [12:0] instruction_pointer;
  logic [4:0]  flag_register;
  logic        int_latched;
  crf_state_t  state;
  logic [2:0]  step;
  logic [3:0]  mul_count;
  logic [7:0]  mul_mplier;
  logic [7:0]  frame_byte;

  //////////////////////////////////////////////////////////////////////////////
  // address forming
  // index with zero high byte
  wire [15:0] idx0_addr = {8'h00, index_reg};
  wire [15:0] idx8_addr = {8'h00, index_reg} + {8'h00, OPERAND1_IN};
  wire [15:0] idx16_addr = {OPERAND1_IN, OPERAND2_IN} + {8'h00, index_reg};
  wire [15:0] direct_addr = {8'h00, OPERAND1_IN};
  logic [15:0] next_operand_addr;
  logic        next_addr_valid;
  logic [1:0]  next_length;
  always_comb begin
    next_operand_addr = 16'h0000;
    next_addr_valid = 1'b0;
    next_length = 2'h1;
    case (MODE_IN)
      crf_pkg::CRF_MODE_INHERENT: next_length = 2'h1;
      crf_pkg::CRF_MODE_IMMEDIATE: next_length = 2'h2;
      crf_pkg::CRF_MODE_DIRECT: begin
        next_operand_addr = direct_addr;
        next_addr_valid = 1'b1;
        next_length = BIT_TEST_IN ? 2'h3 : 2'h2;
      end
      crf_pkg::CRF_MODE_IDX0: begin
        next_operand_addr = idx0_addr;
        next_addr_valid = 1'b1;
        next_length = 2'h1;
      end
      crf_pkg::CRF_MODE_IDX8: begin
        next_operand_addr = idx8_addr;
        next_addr_valid = 1'b1;
        next_length = 2'h2;
      end
      crf_pkg::CRF_MODE_IDX16: begin
        next_operand_addr = idx16_addr;
        next_addr_valid = 1'b1;
        next_length = 2'h3;
      end
      default: next_length = 2'h1;
    endcase
  end

  //////////////////////////////////////////////////////////////////////////////
  // alu
  crf_alu_if alu_bus ();
  crf_alu u_alu (
    .bus (alu_bus)
  );
  wire [7:0] alu_lhs = (ALU_DST_IN == crf_pkg::CRF_DST_X) ? index_reg : accumulator;
  assign alu_bus.op = ALU_OP_IN;
  assign alu_bus.lhs = alu_lhs;
  assign alu_bus.rhs = ALU_DATA_IN;
  assign alu_bus.carry_in = flag_register[`CRF_FLAG_C];
  wire alu_is_add = (ALU_OP_IN == crf_pkg::CRF_ALU_ADD) || (ALU_OP_IN == crf_pkg::CRF_ALU_ADC);
  wire alu_carry_op = (ALU_OP_IN != crf_pkg::CRF_ALU_AND) && (ALU_OP_IN != crf_pkg::CRF_ALU_OR) &&
                      (ALU_OP_IN != crf_pkg::CRF_ALU_XOR) && (ALU_OP_IN != crf_pkg::CRF_ALU_LOAD);

  //////////////////////////////////////////////////////////////////////////////
  // interrupt decision
  // mask blocks service
  wire int_take = int_latched && !flag_register[`CRF_FLAG_I] && (state == CRF_IDLE);
  always_comb begin
    frame_byte = instruction_pointer[7:0];
    case (step)
      3'h0: frame_byte = instruction_pointer[7:0];
      3'h1: frame_byte = {3'h0, instruction_pointer[12:8]};
      3'h2: frame_byte = index_reg;
      3'h3: frame_byte = accumulator;
      3'h4: frame_byte = {`CRF_FLAG_UPPER, flag_register};
      default: frame_byte = 8'h00;
    endcase
  end
  wire stacking = (state == CRF_INT_STACK) || (state == CRF_CALL_STACK);
  wire pushing = stacking || (PUSH_IN && state == CRF_IDLE);
  wire pulling = (state == CRF_RET_PULL) || (PULL_IN && state == CRF_IDLE);
  wire [7:0] push_byte = stacking ? frame_byte : PUSH_DATA_IN;
  wire [12:0] branch_target = instruction_pointer + {{5{BRANCH_OFFSET_IN[7]}}, BRANCH_OFFSET_IN};

  //////////////////////////////////////////////////////////////////////////////
  // sequencing and stack
  always_ff @(posedge CORE_CLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      state <= CRF_IDLE;
      step <= 3'h0;
      stack_pointer <= `CRF_SP_RESET;
      int_latched <= 1'b0;
      mul_count <= 4'h0;
      mul_mplier <= 8'h00;
    end else begin
      // request held while masked; new arrival beats clear
      if (IRQ_IN) begin
        int_latched <= 1'b1;
      end else if (int_take) begin
        int_latched <= 1'b0;
      end
      // post-decrement push, pre-increment pull; six bits wrap
      if (STACK_REINIT_OP_IN && state == CRF_IDLE) begin
        stack_pointer <= `CRF_SP_RESET;
      end else if (pushing) begin
        stack_pointer <= stack_pointer - 6'h01;
      end else if (pulling) begin
        stack_pointer <= stack_pointer + 6'h01;
      end
      case (state)
        CRF_IDLE: begin
          step <= 3'h0;
          if (int_take) begin
            state <= CRF_INT_STACK;
          end else if (INTERRUPT_RETURN_OP_IN) begin
            state <= CRF_RET_PULL;
          end else if (CALL_IN) begin
            state <= CRF_CALL_STACK;
          end else if (PRODUCT_OP_IN) begin
            state <= CRF_MUL_RUN;
            mul_count <= `CRF_MUL_CYCLES - 4'h1;
            mul_mplier <= index_reg;
          end
        end
        CRF_INT_STACK: begin
          step <= step + 3'h1;
          if (step == `CRF_INT_BYTES - 3'h1) begin
            state <= CRF_IDLE;
          end
        end
        CRF_CALL_STACK: begin
          step <= step + 3'h1;
          if (step == `CRF_CALL_BYTES - 3'h1) begin
            state <= CRF_IDLE;
          end
        end
        CRF_RET_PULL: begin
          step <= step + 3'h1;
          if (step == `CRF_INT_BYTES - 3'h1) begin
            state <= CRF_IDLE;
          end
        end
        CRF_MUL_RUN: begin
          mul_count <= mul_count - 4'h1;
          mul_mplier <= mul_mplier >> 1;
          if (mul_count == 4'h0) begin
            state <= CRF_IDLE;
          end
        end
        default: state <= CRF_IDLE;
      endcase
    end
  end

  // shift the multiplicand alongside the multiplier
  logic [15:0] mcand_wide;
  always_ff @(posedge CORE_CLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      mcand_wide <= 16'h0000;
    end else if (state == CRF_IDLE && PRODUCT_OP_IN) begin
      mcand_wide <= {8'h00, accumulator};
    end else if (state == CRF_MUL_RUN) begin
      mcand_wide <= {mcand_wide[14:0], 1'b0};
    end
  end
  wire [15:0] mul_partial = mul_mplier[0] ? mcand_wide : 16'h0000;
  logic [15:0] product;
  always_ff @(posedge CORE_CLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      product <= 16'h0000;
    end else if (state == CRF_IDLE && PRODUCT_OP_IN) begin
      product <= 16'h0000;
    end else if (state == CRF_MUL_RUN) begin
      product <= product + mul_partial;
    end
  end
  wire mul_done = (state == CRF_MUL_RUN) && (mul_count == 4'h0);
  wire [15:0] product_final = product + mul_partial;

  //////////////////////////////////////////////////////////////////////////////
  // instruction pointer
  always_ff @(posedge CORE_CLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      instruction_pointer <= `CRF_PC_RESET;
    end else if (state == CRF_RET_PULL && step == 3'h3) begin
      instruction_pointer[12:8] <= PULL_DATA_IN[4:0];
    end else if (state == CRF_RET_PULL && step == 3'h4) begin
      instruction_pointer[7:0] <= PULL_DATA_IN;
    end else if (JUMP_IN && state == CRF_IDLE) begin
      instruction_pointer <= JUMP_TARGET_IN;
    end else if (BRANCH_IN && BRANCH_TAKEN_IN && state == CRF_IDLE) begin
      instruction_pointer <= branch_target;
    end else if (FETCH_IN && state == CRF_IDLE) begin
      instruction_pointer <= instruction_pointer + 13'h0001;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // working registers and flags
  wire alu_write = ALU_GO_IN && state == CRF_IDLE;
  always_ff @(posedge CORE_CLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      accumulator <= 8'h00;
      index_reg <= 8'h00;
      flag_register <= 5'h08;
    end else if (state == CRF_RET_PULL) begin
      if (step == 3'h0) flag_register <= PULL_DATA_IN[4:0];
      if (step == 3'h1) accumulator <= PULL_DATA_IN;
      if (step == 3'h2) index_reg <= PULL_DATA_IN;
    end else if (state == CRF_INT_STACK) begin
      if (step == `CRF_INT_BYTES - 3'h1) flag_register[`CRF_FLAG_I] <= 1'b1;
    end else if (mul_done) begin
      // high to index, low to accumulator
      index_reg <= product_final[15:8];
      accumulator <= product_final[7:0];
      flag_register[`CRF_FLAG_H] <= 1'b0;
      flag_register[`CRF_FLAG_C] <= 1'b0;
    end else if (state == CRF_IDLE) begin
      if (alu_write) begin
        if (ALU_DST_IN == crf_pkg::CRF_DST_A) accumulator <= alu_bus.result;
        if (ALU_DST_IN == crf_pkg::CRF_DST_X) index_reg <= alu_bus.result;
        flag_register[`CRF_FLAG_N] <= alu_bus.result[7];
        flag_register[`CRF_FLAG_Z] <= (alu_bus.result == 8'h00);
        if (alu_is_add) flag_register[`CRF_FLAG_H] <= alu_bus.half_carry;
        if (alu_carry_op) flag_register[`CRF_FLAG_C] <= alu_bus.carry_out;
      end else if (BIT_TEST_IN) begin
        flag_register[`CRF_FLAG_C] <= BIT_VALUE_IN;
      end else if (SET_CARRY_IN) begin
        flag_register[`CRF_FLAG_C] <= 1'b1;
      end else if (CLEAR_CARRY_IN) begin
        flag_register[`CRF_FLAG_C] <= 1'b0;
      end
      if (SET_MASK_IN) begin
        flag_register[`CRF_FLAG_I] <= 1'b1;
      end else if (CLEAR_MASK_IN) begin
        flag_register[`CRF_FLAG_I] <= 1'b0;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // outputs; stack address taken after pull increment is applied
  wire [5:0] pull_slot = stack_pointer + 6'h01;
  always_ff @(posedge CORE_CLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      OPERAND_ADDR_OUT <= 16'h0000;
      ADDR_VALID_OUT <= 1'b0;
      INSTR_LENGTH_OUT <= 2'h1;
      STACK_WDATA_OUT <= 8'h00;
      STACK_WRITE_OUT <= 1'b0;
    end else begin
      OPERAND_ADDR_OUT <= next_operand_addr;
      ADDR_VALID_OUT <= next_addr_valid;
      INSTR_LENGTH_OUT <= next_length;
      STACK_WDATA_OUT <= push_byte;
      STACK_WRITE_OUT <= pushing;
    end
  end
  assign STACK_ADDR_OUT = {3'h0, `CRF_SP_UPPER, (pulling ? pull_slot : stack_pointer)};
  assign INSTRUCTION_POINTER_OUT = {3'h0, instruction_pointer};
  assign FLAG_REGISTER_OUT = {`CRF_FLAG_UPPER, flag_register};
  assign ACCUMULATOR_OUT = accumulator;
  assign INDEX_OUT = index_reg;
  assign INT_PENDING_OUT = int_latched;
  assign INT_TAKE_OUT = int_take;
  assign BUSY_OUT = (state != CRF_IDLE);
endmodule // crf_core
`default_nettype wire

// ==== test/crf_core_sva.sv ====
// assertion checker bound to the cpu register block
`timescale 1ns/1ps
`default_nettype none
module crf_core_sva (
  input wire logic               CORE_CLK_IN,
  input wire logic               RST_B_IN,
  input wire logic               FETCH_IN,
  input wire logic               JUMP_IN,
  input wire logic               BRANCH_IN,
  input wire crf_pkg::crf_mode_t MODE_IN,
  input wire logic [7:0]         OPERAND1_IN,
  input wire logic               PRODUCT_OP_IN,
  input wire logic [7:0]         INDEX_OUT,
  input wire logic [15:0]        STACK_ADDR_OUT,
  input wire logic [15:0]        INSTRUCTION_POINTER_OUT,
  input wire logic [7:0]         FLAG_REGISTER_OUT,
  input wire logic [15:0]        OPERAND_ADDR_OUT,
  input wire logic               INT_TAKE_OUT,
  input wire logic               BUSY_OUT
);
  default clocking cb @(posedge CORE_CLK_IN);
  endclocking
  default disable iff (!RST_B_IN);
  // interrupt entry outranks return, call and product requests when idle
  wire logic idle;
  assign idle = !BUSY_OUT && !INT_TAKE_OUT;
  //////////////////////////////////////////////////////////////////////////////
  AST_FLAG_TOP: assert property (FLAG_REGISTER_OUT[7:5] == 3'h7)
    else $error("flag top bits not ones");
  AST_IP_TOP: assert property (INSTRUCTION_POINTER_OUT[15:13] == 3'h0)
    else $error("ip top bits not zero");
  AST_STACK_PAGE: assert property (STACK_ADDR_OUT[15:6] == 10'h003)
    else $error("stack address off page");
  AST_FETCH_STEP: assert property (idle && FETCH_IN && !JUMP_IN && !BRANCH_IN |=>
    INSTRUCTION_POINTER_OUT == (($past(INSTRUCTION_POINTER_OUT) + 16'h1) & 16'h1fff))
    else $error("fetch did not step ip");
  AST_IDX0: assert property (MODE_IN == crf_pkg::CRF_MODE_IDX0 |=>
    OPERAND_ADDR_OUT == {8'h00, $past(INDEX_OUT)})
    else $error("indexed address wrong");
  AST_IDX8: assert property (MODE_IN == crf_pkg::CRF_MODE_IDX8 |=>
    OPERAND_ADDR_OUT == {8'h00, $past(INDEX_OUT)} + {8'h00, $past(OPERAND1_IN)})
    else $error("short offset address wrong");
  AST_PRODUCT_TIME: assert property (idle && PRODUCT_OP_IN |=>
    BUSY_OUT [*8] ##1 BUSY_OUT [*3] ##1 !BUSY_OUT)
    else $error("product length wrong");
  AST_INT_FRAME: assert property (INT_TAKE_OUT |-> !FLAG_REGISTER_OUT[3] ##6
    FLAG_REGISTER_OUT[3] && ((STACK_ADDR_OUT - $past(STACK_ADDR_OUT, 6)) & 16'h3f) == 16'h3b)
    else $error("interrupt frame wrong");
  COV_PRODUCT: cover property (idle && PRODUCT_OP_IN);
  COV_INT: cover property (INT_TAKE_OUT);
  COV_IDX16: cover property (MODE_IN == crf_pkg::CRF_MODE_IDX16);
endmodule // crf_core_sva
bind crf_core crf_core_sva i_sva (.CORE_CLK_IN, .RST_B_IN, .FETCH_IN, .JUMP_IN, .BRANCH_IN,
  .MODE_IN, .OPERAND1_IN, .PRODUCT_OP_IN, .INDEX_OUT, .STACK_ADDR_OUT, .INSTRUCTION_POINTER_OUT,
  .FLAG_REGISTER_OUT, .OPERAND_ADDR_OUT, .INT_TAKE_OUT, .BUSY_OUT);
`default_nettype wire

// ==== test/crf_core_tb_top.sv ====
// self-checking bench for the cpu register block
`timescale 1ns/1ps
`default_nettype none
module crf_core_tb_top;
  logic               clk = 1'b0, rst_b = 1'b0, bt = 1'b0, bv = 1'b0;
  logic [15:0]        p = 16'h0000, s = 16'hf83d, pr;
  logic [12:0]        jt = 13'h0000;
  logic [7:0]         bo = 8'h00, o1 = 8'h00, o2 = 8'h00, ad = 8'h00, pd = 8'h00, a, x, fl, wd;
  crf_pkg::crf_alu_t  ops[10] = '{crf_pkg::CRF_ALU_LOAD, crf_pkg::CRF_ALU_ADC,
    crf_pkg::CRF_ALU_SBC, crf_pkg::CRF_ALU_AND, crf_pkg::CRF_ALU_XOR, crf_pkg::CRF_ALU_OR,
    crf_pkg::CRF_ALU_SHL, crf_pkg::CRF_ALU_ROR, crf_pkg::CRF_ALU_SHR, crf_pkg::CRF_ALU_ROL};
  logic [7:0]         opd[10] = '{8'hff, 8'h01, 8'h00, 8'h3c, 8'h3c,
    8'h81, 8'h00, 8'h00, 8'h00, 8'h00};
  // expected accumulator and flags after each op of the sweep
  logic [15:0]        af[10] = '{16'hffe4, 16'h00f3, 16'hfff5, 16'h3cf1, 16'h00f3,
    16'h81f5, 16'h02f1, 16'h81f4, 16'h40f1, 16'h81f4};
  crf_pkg::crf_mode_t mode = crf_pkg::CRF_MODE_INHERENT;
  crf_pkg::crf_alu_t  aop = crf_pkg::CRF_ALU_NONE;
  crf_pkg::crf_dst_t  dst = crf_pkg::CRF_DST_NONE;
  logic [15:0]        sa, ip, oa, q_exp[$];
  logic [1:0]         il;
  logic               av, pend, tk, busy, ww;
  int                 n_checks = 0, n_mismatch = 0, q_sel[$];
  event               look;
  string              nm[9] = '{"acc", "index", "stack", "ip", "flags", "addr", "len", "pend",
    "wdata"};
  localparam logic [11:0] len_by_mode = 12'he69;
  crf_core i_dut (.CORE_CLK_IN(clk), .RST_B_IN(rst_b), .FETCH_IN(p[0]), .JUMP_IN(p[1]),
    .JUMP_TARGET_IN(jt), .BRANCH_IN(p[2]), .BRANCH_TAKEN_IN(bt), .BRANCH_OFFSET_IN(bo),
    .MODE_IN(mode), .OPERAND1_IN(o1), .OPERAND2_IN(o2), .ALU_GO_IN(p[3]), .ALU_OP_IN(aop),
    .ALU_DST_IN(dst), .ALU_DATA_IN(ad), .BIT_TEST_IN(p[4]), .BIT_VALUE_IN(bv),
    .SET_MASK_IN(p[5]), .CLEAR_MASK_IN(p[6]), .SET_CARRY_IN(p[7]), .CLEAR_CARRY_IN(p[8]),
    .PUSH_IN(p[9]), .PUSH_DATA_IN(pd), .PULL_IN(p[10]), .STACK_REINIT_OP_IN(p[11]),
    .CALL_IN(p[12]), .PRODUCT_OP_IN(p[13]), .IRQ_IN(p[14]), .INTERRUPT_RETURN_OP_IN(p[15]),
    .PULL_DATA_IN(pd), .ACCUMULATOR_OUT(a), .INDEX_OUT(x), .STACK_ADDR_OUT(sa),
    .INSTRUCTION_POINTER_OUT(ip), .FLAG_REGISTER_OUT(fl), .OPERAND_ADDR_OUT(oa),
    .ADDR_VALID_OUT(av), .INSTR_LENGTH_OUT(il), .INT_PENDING_OUT(pend), .INT_TAKE_OUT(tk),
    .STACK_WDATA_OUT(wd), .STACK_WRITE_OUT(ww), .BUSY_OUT(busy));
  //////////////////////////////////////////////////////////////////////////////
  always #20 clk = ~clk;
  function automatic logic [15:0] lfsr(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction
  function automatic logic [15:0] seen(input int k);
    case (k)
      0: return {8'h00, a};
      1: return {8'h00, x};
      2: return sa;
      3: return ip;
      4: return {8'h00, fl};
      5: return oa;
      6: return {13'h0000, av, il};
      7: return {15'h0000, pend};
      default: return {7'h00, ww, wd};
    endcase
  endfunction
  task automatic note(input int k, input logic [15:0] e);
    q_sel.push_back(k);
    q_exp.push_back(e);
    -> look;
  endtask
  task automatic check(input int k, input logic [15:0] e, input logic [15:0] g);
    n_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", nm[k], e, g);
    end
  endtask
  // one request pulse; long operations and interrupt entry are waited out
  task automatic go(input int i);
    @(posedge clk) p <= 16'h0001 << i;
    @(posedge clk) p <= 16'h0000;
    @(negedge clk);
    for (int k = 0; k < 40 && (busy !== 1'b0 || tk === 1'b1); k++) @(negedge clk);
  endtask
  task automatic alu(input crf_pkg::crf_alu_t op, input crf_pkg::crf_dst_t d, input logic [7:0] v);
    @(posedge clk) begin
      aop <= op;
      dst <= d;
      ad <= v;
    end
    go(3);
  endtask
  task automatic close_out;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // monitor drains the notes as soon as results are settled
  always begin
    int k;
    @(look);
    while (q_sel.size() > 0) begin
      k = q_sel.pop_front();
      check(k, q_exp.pop_front(), seen(k));
    end
  end
  // whole run is about 330 cycles against a limit of 50000 cycles, so this is a generous limit
  initial begin
    #2000000;
    n_mismatch++;
    close_out;
  end
  initial begin
    repeat (4) @(posedge clk);
    rst_b <= 1'b1;
    @(negedge clk);
    note(2, 16'h00ff);
    note(4, 16'h00e8);
    alu(crf_pkg::CRF_ALU_LOAD, crf_pkg::CRF_DST_A, 8'h0f);
    alu(crf_pkg::CRF_ALU_ADD, crf_pkg::CRF_DST_A, 8'h01);
    note(4, 16'h00f8);
    alu(crf_pkg::CRF_ALU_ADD, crf_pkg::CRF_DST_A, 8'hf0);
    note(4, 16'h00eb);
    alu(crf_pkg::CRF_ALU_SUB, crf_pkg::CRF_DST_A, 8'h01);
    note(0, 16'h00ff);
    note(4, 16'h00ed);
    go(8);
    @(posedge clk) begin
      bv <= 1'b1;
      mode <= crf_pkg::CRF_MODE_DIRECT;
    end
    go(4);
    note(6, 16'h0007);
    go(8);
    go(7);
    note(4, 16'h00ed);
    @(posedge clk) jt <= 13'h1fff;
    go(1);
    go(0);
    note(3, 16'h0000);
    @(posedge clk) begin
      jt <= 13'h0100;
      bt <= 1'b1;
      bo <= 8'h80;
    end
    go(1);
    go(2);
    @(posedge clk) bt <= 1'b0;
    go(2);
    note(3, 16'h0080);
    repeat (64) go(9);
    note(2, 16'h00ff);
    repeat (3) go(9);
    go(10);
    note(2, 16'h00fd);
    go(11);
    go(10);
    note(2, 16'h00c0);
    go(11);
    go(12);
    note(2, 16'h00fd);
    go(14);
    note(7, 16'h0001);
    go(6);
    note(2, 16'h00f8);
    note(4, 16'h00ed);
    note(8, 16'h01e5);
    @(posedge clk) pd <= 8'he0;
    go(15);
    note(4, 16'h00e0);
    note(3, 16'h00e0);
    for (int m = 0; m < 6; m++) begin
      s = lfsr(s);
      alu(crf_pkg::CRF_ALU_LOAD, crf_pkg::CRF_DST_X, s[7:0]);
      @(posedge clk) begin
        mode <= crf_pkg::crf_mode_t'(m);
        o1 <= s[15:8];
        o2 <= s[11:4];
      end
      @(posedge clk);
      @(negedge clk);
      note(6, {13'h0000, m > 1, len_by_mode[2 * m +: 2]});
      if (m > 1) note(5, m == 2 ? {8'h00, s[15:8]} : m == 3 ? {8'h00, s[7:0]} : m == 4 ?
        {8'h00, s[7:0]} + {8'h00, s[15:8]} : {s[15:8], s[11:4]} + {8'h00, s[7:0]});
    end
    // carry starts clear here, so the sweep is fully known
    for (int j = 0; j < 10; j++) begin
      alu(ops[j], crf_pkg::CRF_DST_A, opd[j]);
      note(0, {8'h00, af[j][15:8]});
      note(4, {8'h00, af[j][7:0]});
    end
    repeat (3) begin
      s = lfsr(s);
      pr = {8'h00, s[7:0]} * {8'h00, s[15:8]};
      alu(crf_pkg::CRF_ALU_LOAD, crf_pkg::CRF_DST_A, s[7:0]);
      alu(crf_pkg::CRF_ALU_LOAD, crf_pkg::CRF_DST_X, s[15:8]);
      go(13);
      note(1, {8'h00, pr[15:8]});
      note(0, {8'h00, pr[7:0]});
    end
    // let the monitor drain the last notes first
    @(posedge clk);
    close_out;
  end
endmodule // crf_core_tb_top
`default_nettype wire
